// File: design/tmsl_cfg.svh
// Constants for the timer mode select logic
`ifndef TMSL_CFG_SVH
`define TMSL_CFG_SVH
`define TMSL_T0_MODE_LSB   0
`define TMSL_T0_CT_BIT     2
`define TMSL_T0_GATE_BIT   3
`define TMSL_T1_MODE_LSB   4
`define TMSL_CFG_RESET     8'h00
`define TMSL_LEN13         13
`define TMSL_PRESC_DIV_A   12
`define TMSL_PRESC_DIV_B   1
`endif

// File: design/tmsl_pkg.sv
// Types for the timer mode select logic
package tmsl_pkg;
    typedef enum logic [1:0] {
        TMSL_MODE13   = 2'b00,
        TMSL_MODE16   = 2'b01,
        TMSL_MODE8AR  = 2'b10,
        TMSL_MODEOFF  = 2'b11
    } tmsl_mode_t;
endpackage : tmsl_pkg

// File: design/tmsl_cnt_if.sv
// Interface between the mode logic and one counter
`timescale 1ns/1ps
interface tmsl_cnt_if;
    logic               tick;
    tmsl_pkg::tmsl_mode_t mode;
    logic [15:0]        value;
    logic               overflow;
    modport ctrl (output tick, output mode, input value, input overflow);
    modport cnt  (input tick, input mode, output value, output overflow);
endinterface : tmsl_cnt_if

// File: design/tmsl_counter.sv
// One counter with 13, 16, 8-bit auto-reload and stopped modes
`timescale 1ns/1ps
module tmsl_counter (
    input  wire logic   clock,
    input  wire logic   rstn,
    tmsl_cnt_if.cnt     port
);
    logic [15:0] value;
    logic        overflow;
    logic [15:0] next_value;
    logic        next_overflow;

    always_comb begin
        next_value    = value;
        next_overflow = 1'b0;
        if (port.tick) begin
            case (port.mode)
                tmsl_pkg::TMSL_MODE13: begin
                    // Low five bits feed the high byte
                    if (value[4:0] == 5'h1F) begin
                        next_value[4:0]  = 5'h00;
                        next_value[15:8] = value[15:8] + 8'h01;
                        next_overflow    = (value[15:8] == 8'hFF);
                    end else begin
                        next_value[4:0] = value[4:0] + 5'h01;
                    end
                end
                tmsl_pkg::TMSL_MODE16: begin
                    next_value    = value + 16'h0001;
                    next_overflow = (value == 16'hFFFF);
                end
                tmsl_pkg::TMSL_MODE8AR: begin
                    if (value[7:0] == 8'hFF) begin
                        next_value[7:0] = value[15:8];
                        next_overflow   = 1'b1;
                    end else begin
                        next_value[7:0] = value[7:0] + 8'h01;
                    end
                end
                default: begin
                    next_value = value;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            value    <= 16'h0000;
            overflow <= 1'b0;
        end else begin
            value    <= next_value;
            overflow <= next_overflow;
        end
    end

    assign port.value    = value;
    assign port.overflow = overflow;
endmodule : tmsl_counter

// File: design/tmsl_timer_mode.sv
// Mode selection for two counter/timers; gating and count source select for Timer 0 only
`timescale 1ns/1ps
`include "tmsl_cfg.svh"
module tmsl_timer_mode #(
    parameter int PRESC_DIV = `TMSL_PRESC_DIV_A
) (
    input  wire logic         clock,
    input  wire logic         rstn,
    input  wire logic         cfgWrite,
    input  wire logic [7:0]   cfgData,
    input  wire logic         timer0Run,
    input  wire logic         timer1Run,
    input  wire logic         timer0PrescaleSel,
    input  wire logic         extGateInput,
    input  wire logic         timer0ExtCountPin,
    output logic [7:0]        cfgReg,
    output logic              timer0Enabled,
    output logic [15:0]       timer0Value,
    output logic              timer0Overflow,
    output logic [15:0]       timer1Value,
    output logic              timer1Overflow
);
    // The prescale counter is eight bits wide
    if (PRESC_DIV < 1 || PRESC_DIV > 255) begin : g_bad_div
        $error("PRESC_DIV out of range");
    end

    tmsl_cnt_if t0 ();
    tmsl_cnt_if t1 ();

    logic [7:0] next_cfgReg;
    logic [7:0] prescCnt;
    logic [7:0] next_prescCnt;
    logic       prescTick;
    logic       next_prescTick;
    logic       countPinPrev;
    logic       next_countPinPrev;
    logic       next_timer0Enabled;

    logic                 timer0GateCtrl;
    logic                 timer0CountSelect;
    tmsl_pkg::tmsl_mode_t t0Mode;
    tmsl_pkg::tmsl_mode_t t1Mode;
    logic                 fallEdge;
    logic                 t0Source;

    always_comb begin
        next_cfgReg = cfgWrite ? cfgData : cfgReg;
    end

    // Field decode
    assign timer0GateCtrl    = cfgReg[`TMSL_T0_GATE_BIT];
    assign timer0CountSelect = cfgReg[`TMSL_T0_CT_BIT];
    assign t0Mode = tmsl_pkg::tmsl_mode_t'(cfgReg[`TMSL_T0_MODE_LSB +: 2]);
    assign t1Mode = tmsl_pkg::tmsl_mode_t'(cfgReg[`TMSL_T1_MODE_LSB +: 2]);

    // Prescaler: divide chosen by prescale select, kept as one-cycle enable
    always_comb begin
        next_prescTick = 1'b0;
        next_prescCnt  = prescCnt + 8'h01;
        if (timer0PrescaleSel) begin
            next_prescCnt  = 8'h00;
            next_prescTick = 1'b1;
        end else if (prescCnt >= 8'(PRESC_DIV - 1)) begin
            next_prescCnt  = 8'h00;
            next_prescTick = 1'b1;
        end
    end

    // Pin is taken as synchronous; one register gives edge history
    always_comb begin
        next_countPinPrev = timer0ExtCountPin;
    end
    assign fallEdge = countPinPrev & ~timer0ExtCountPin;

    // Gate qualifies run bit with pin level
    always_comb begin
        if (timer0GateCtrl) begin
            next_timer0Enabled = timer0Run & extGateInput;
        end else begin
            next_timer0Enabled = timer0Run;
        end
    end

    assign t0Source = timer0CountSelect ? fallEdge : prescTick;
    // Enable is registered, so counting lags the run bit by one cycle
    assign t0.tick = timer0Enabled & t0Source;
    // Mode 11 on Timer 0 acts as stopped too; no split-timer behaviour here
    assign t0.mode = t0Mode;
    assign t1.tick = timer1Run & prescTick & (t1Mode != tmsl_pkg::TMSL_MODEOFF);
    assign t1.mode = t1Mode;

    tmsl_counter u_t0 (
        .clock (clock),
        .rstn  (rstn),
        .port  (t0.cnt)
    );
    tmsl_counter u_t1 (
        .clock (clock),
        .rstn  (rstn),
        .port  (t1.cnt)
    );

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cfgReg        <= `TMSL_CFG_RESET;
            prescCnt      <= 8'h00;
            prescTick     <= 1'b0;
            countPinPrev  <= 1'b1;
            timer0Enabled <= 1'b0;
        end else begin
            cfgReg        <= next_cfgReg;
            prescCnt      <= next_prescCnt;
            prescTick     <= next_prescTick;
            countPinPrev  <= next_countPinPrev;
            timer0Enabled <= next_timer0Enabled;
        end
    end

    assign timer0Value    = t0.value;
    assign timer0Overflow = t0.overflow;
    assign timer1Value    = t1.value;
    assign timer1Overflow = t1.overflow;
endmodule : tmsl_timer_mode

// File: verif/tmsl_pins.sv
// Far-side model of the gate pin and the external count pin
`timescale 1ns/1ps
module tmsl_pins (
    input  wire logic clock,
    input  wire logic gateReq,
    input  wire logic pulseReq,
    output logic      gatePin,
    output logic      countPin
);
    assign gatePin = gateReq;
    initial countPin = 1'b1;
    // Idles high, so a release never fakes a falling edge
    always @(posedge clock) countPin <= pulseReq ? ~countPin : 1'b1;
endmodule : tmsl_pins

// File: verif/tmsl_timer_mode_chk.sv
// Port assertions for the timer mode select logic
`timescale 1ns/1ps
module tmsl_timer_mode_chk (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        cfgWrite,
    input wire logic [7:0]  cfgData,
    input wire logic        timer0Run,
    input wire logic        extGateInput,
    input wire logic        timer0ExtCountPin,
    input wire logic [7:0]  cfgReg,
    input wire logic        timer0Enabled,
    input wire logic [15:0] timer0Value,
    input wire logic        timer0Overflow
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    chk_cfg_load: assert property (cfgWrite |=> cfgReg == $past(cfgData))
        else $error("cfg load");
    chk_gate_open: assert property (!cfgReg[3] |=> timer0Enabled == $past(timer0Run))
        else $error("gate open");
    chk_gate_pin: assert property
        (cfgReg[3] |=> timer0Enabled == $past(timer0Run && extGateInput)) else $error("gate pin");
    // Three low samples cover the tick pipeline
    chk_t0_hold: assert property (!timer0Enabled [*3] |=> $stable(timer0Value))
        else $error("count while off");
    chk_t0_stop: assert property
        (cfgReg[1:0] == 2'b11 |=> $stable(timer0Value)) else $error("mode 3 moved");
    chk_ext_count: assert property
        (cfgReg[2] && cfgReg[1:0] == 2'b01 && timer0Enabled && $fell(timer0ExtCountPin)
         |=> timer0Value == 16'($past(timer0Value) + 16'h0001)) else $error("edge count");
    chk_wrap_ovf: assert property
        ($past(timer0Value) == 16'hFF1F && timer0Value == 16'h0000 |-> timer0Overflow)
        else $error("no overflow");
    chk_ovf_pulse: assert property (timer0Overflow |=> !timer0Overflow)
        else $error("overflow too long");
    cover property (timer0Overflow);
    cover property (cfgReg[3] && timer0Run && !extGateInput);
    cover property (timer0Enabled && $fell(timer0ExtCountPin));
endmodule : tmsl_timer_mode_chk
bind tmsl_timer_mode tmsl_timer_mode_chk chk_u (.*);

// File: verif/tb.sv
// Self-checking bench for the timer mode select logic
`timescale 1ns/1ps
module tb;
    logic        clock = 0, rstn = 0, cfgWrite = 0, t0Run = 0, t1Run = 0, presc = 1;
    logic        gateReq = 0, pulseReq = 0, gatePin, countPin, t0En, t0Ovf, t1Ovf;
    logic [7:0]  cfgData = 8'h00, cfgReg;
    logic [15:0] t0Val, t1Val, v;
    int          error_cnt = 0, compares = 0;
    always #12.5 clock = ~clock;
    tmsl_pins pins_u (.clock(clock), .gateReq(gateReq), .pulseReq(pulseReq),
        .gatePin(gatePin), .countPin(countPin));
    // Short prescale keeps the timer-mode check brief
    tmsl_timer_mode #(.PRESC_DIV(4)) dut_u (.clock(clock), .rstn(rstn), .cfgWrite(cfgWrite),
        .cfgData(cfgData), .timer0Run(t0Run), .timer1Run(t1Run), .timer0PrescaleSel(presc),
        .extGateInput(gatePin), .timer0ExtCountPin(countPin), .cfgReg(cfgReg),
        .timer0Enabled(t0En), .timer0Value(t0Val), .timer0Overflow(t0Ovf),
        .timer1Value(t1Val), .timer1Overflow(t1Ovf));
    task automatic tally_and_finish();
        if (error_cnt == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask : cyc
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cfg(input logic [7:0] d);
        cfgData = d;
        cfgWrite = 1;
        cyc(1);
        cfgWrite = 0;
        chk(cfgReg, d);
    endtask : cfg
    task automatic s_gate();
        for (int i = 0; i < 8; i++) begin
            cfg({4'h0, i[2], 3'b001});
            t0Run = i[1];
            gateReq = i[0];
            cyc(2);
            chk(t0En, i[1] & (~i[2] | i[0]));
            v = t0Val;
            cyc(3);
            chk(t0Val, v + ((i[1] & (~i[2] | i[0])) ? 16'h0003 : 16'h0000));
        end
    endtask : s_gate
    task automatic s_count();
        cfg(8'h05);
        cyc(2);
        v = t0Val;
        pulseReq = 1;
        cyc(20);
        pulseReq = 0;
        cyc(4);
        chk(t0Val, v + 16'h000A);
        cfg(8'h01);
        presc = 0;
        cyc(2);
        v = t0Val;
        cyc(40);
        chk(t0Val - v, 16'h000A);
        presc = 1;
    endtask : s_count
    task automatic s_stop();
        cfg(8'h33);
        t1Run = 1;
        v = t0Val;
        cyc(6);
        chk(t0Val, v);
        chk(t1Val, 16'h0000);
        cfg(8'h12);
        cyc(300);
        chk(t0Val[15:8], 16'h0000);
        chk(t1Val !== 16'h0000, 16'h0001);
    endtask : s_stop
    task automatic s_wrap();
        int n;
        n = 0;
        cfg(8'h00);
        while (t0Ovf !== 1'b1 && n < 9000) begin
            cyc(1);
            n++;
        end
        chk(n < 9000, 16'h0001);
        if (n >= 9000) begin
            tally_and_finish();
        end
        chk({t0Val[15:8], t0Val[4:0]}, 16'h0000);
    endtask : s_wrap
    initial begin
        cyc(10);
        rstn = 1;
        cyc(1);
        s_gate();
        s_count();
        s_stop();
        s_wrap();
        tally_and_finish();
    end
endmodule : tb
